// [core/utci_pkg.sv]
// constants for the transceiver control and identification block
// Operation
// - writing one to soft reset resets the module, clears transceiver and regulator enables
// - the soft reset bit clears itself after the reset; zero means normal operation
// - pull-up select one turns the internal plus-line pull-up on, zero off
// - with resume enable set, a set resume flag raises the asynchronous wakeup
// - resume flag sets on K-state while enabled, suspended and in stop3; wakes chip
// - clearing resume enable clears the resume flag; no other clear exists
// - regulator enable one turns the regulator on, zero puts it in off mode
// - transceiver enable zero disables it and floats both data lines
// - identity register returns a fixed six-bit configuration number
// - identity inverse register returns the one's complement of that field
// - revision register returns a fixed eight-bit revision number
// - three milliseconds of continuous bus idle sets the idle sleep flag
`default_nettype none
package utci_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_ID = 12'h004;
  localparam logic [11:0] ADDR_ID_INV = 12'h008;
  localparam logic [11:0] ADDR_REV = 12'h00c;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h010;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;
  // ==========================================================
  // control register fields
  localparam int BIT_SOFT_RESET = 7;
  localparam int BIT_PULLUP = 6;
  localparam int BIT_RESUME_EN = 5;
  localparam int BIT_RESUME_FLAG = 4;
  localparam int BIT_REG_EN = 2;
  localparam int BIT_BUS_TRANSCEIVER_EN = 0;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'h65;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ==========================================================
  // interrupt status bits
  localparam int IRQ_SLEEP = 0;
  localparam int IRQ_RESUME = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // ==========================================================
  // identity values, arbitrary
  localparam logic [5:0] PERIPHERAL_ID = 6'h15;
  localparam logic [7:0] CORE_REVISION = 8'h21;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 100000000;
  localparam int IDLE_SUSPEND_US = 3000;
  localparam int IDLE_SUSPEND_CYCLES = IDLE_SUSPEND_US * (CLK_HZ / 1000000);
  localparam int IDLE_CNT_W = 19;
  localparam int RESET_HOLD_CYCLES = 2;
  // ==========================================================
  // line states
  typedef enum logic [1:0] {
    LINE_SE0 = 2'b00,
    LINE_J = 2'b10,
    LINE_K = 2'b01,
    LINE_SE1 = 2'b11
  } utci_line_t;
endpackage
`default_nettype wire

// [core/utci_idle_timer.sv]
// bus idle timer that flags suspend after a continuous idle span
`default_nettype none
module utci_idle_timer #(
  parameter int unsigned IDLE_CYCLES = 300000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // bus state
  input wire logic enable,
  input wire logic bus_idle,
  // result
  output logic idle_sleep_flag
);
  logic [utci_pkg::IDLE_CNT_W-1:0] count;
  logic [utci_pkg::IDLE_CNT_W-1:0] next_count;
  logic next_flag;
  localparam logic [utci_pkg::IDLE_CNT_W-1:0] LIMIT = utci_pkg::IDLE_CNT_W'(IDLE_CYCLES - 1);

  // any activity or a low enable restarts the span; the flag holds until either occurs
  always_comb begin
    next_count = count;
    next_flag = idle_sleep_flag;
    if (!enable || !bus_idle) begin
      next_count = '0;
      next_flag = 1'b0;
    end else if (count == LIMIT) begin
      next_flag = 1'b1;
    end else begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count <= '0;
      idle_sleep_flag <= 1'b0;
    end else begin
      count <= next_count;
      idle_sleep_flag <= next_flag;
    end
  end
endmodule
`default_nettype wire

// [core/utci_top.sv]
// transceiver, regulator and identification control with apb slave
`default_nettype none
module utci_top #(
  parameter int unsigned IDLE_CYCLES = utci_pkg::IDLE_SUSPEND_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus line receivers
  input wire logic bus_plus_line_in,
  input wire logic bus_minus_line_in,
  // chip power state
  input wire logic chip_in_stop3,
  // transceiver and power controls
  output logic bus_plus_line_oe_n,
  output logic bus_minus_line_oe_n,
  output logic dp_pullup_on,
  output logic regulator_on,
  output logic transceiver_on,
  output logic module_reset,
  // status and interrupts
  output logic idle_sleep_flag,
  output logic wakeup_irq,
  output logic irq
);
  logic dp_pullup_select;
  logic lowpower_resume_enable;
  logic lowpower_resume_flag;
  logic regulator_enable;
  logic transceiver_enable;
  logic module_soft_reset;
  logic [1:0] reset_cnt;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic sleep_seen;
  // next values of the control, interrupt and apb registers; timer and line decode wires
  logic next_pullup;
  logic next_resume_en;
  logic next_resume_flag;
  logic next_reg_en;
  logic next_bus_transceiver_en;
  logic next_soft_reset;
  logic [1:0] next_reset_cnt;
  logic [1:0] next_irq_status;
  logic [1:0] next_irq_mask;
  logic next_sleep_seen;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic next_pready;
  logic sleep_raw;
  logic bus_idle;
  logic k_state;
  // bus decode
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic [7:0] ctrl_view;
  // next values of the registered pins
  logic next_plus_oe_n;
  logic next_minus_oe_n;
  logic next_pullup_on;
  logic next_regulator_on;
  logic next_transceiver_on;
  logic next_module_reset;
  logic next_idle_sleep;
  logic next_wakeup;
  logic next_irq;

  // ==========================================================
  // line decode
  assign bus_idle = {bus_plus_line_in, bus_minus_line_in} == utci_pkg::LINE_J;
  assign k_state = {bus_plus_line_in, bus_minus_line_in} == utci_pkg::LINE_K;

  // suspend detection; held in reset while the module reset runs
  utci_idle_timer #(
    .IDLE_CYCLES(IDLE_CYCLES)
  ) u_idle (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .enable(transceiver_enable && !module_soft_reset),
    .bus_idle(bus_idle),
    .idle_sleep_flag(sleep_raw)
  );

  // ==========================================================
  // apb decode; zero-wait access, answer in the first access cycle
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;
  // pready is a one-cycle pulse, so a held access cannot write twice
  assign wr_ctrl = wr_en && paddr == utci_pkg::ADDR_CTRL;
  assign wr_status = wr_en && paddr == utci_pkg::ADDR_IRQ_STATUS;
  assign wr_mask = wr_en && paddr == utci_pkg::ADDR_IRQ_MASK;
  always_comb begin
    unique case (paddr)
      utci_pkg::ADDR_CTRL, utci_pkg::ADDR_ID, utci_pkg::ADDR_ID_INV,
      utci_pkg::ADDR_REV, utci_pkg::ADDR_IRQ_STATUS, utci_pkg::ADDR_IRQ_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // control view; unimplemented bits 3 and 1 stay zero
  always_comb begin
    ctrl_view = utci_pkg::CTRL_RESET;
    ctrl_view[utci_pkg::BIT_SOFT_RESET] = module_soft_reset;
    ctrl_view[utci_pkg::BIT_PULLUP] = dp_pullup_select;
    ctrl_view[utci_pkg::BIT_RESUME_EN] = lowpower_resume_enable;
    ctrl_view[utci_pkg::BIT_RESUME_FLAG] = lowpower_resume_flag;
    ctrl_view[utci_pkg::BIT_REG_EN] = regulator_enable;
    ctrl_view[utci_pkg::BIT_BUS_TRANSCEIVER_EN] = transceiver_enable;
  end

  // ==========================================================
  // control register next state
  always_comb begin
    next_pullup = dp_pullup_select;
    next_resume_en = lowpower_resume_enable;
    next_reg_en = regulator_enable;
    next_bus_transceiver_en = transceiver_enable;
    next_soft_reset = module_soft_reset;
    next_reset_cnt = reset_cnt;
    next_resume_flag = lowpower_resume_flag;
    if (wr_ctrl) begin
      if (pwdata[utci_pkg::BIT_SOFT_RESET]) begin
        // a reset write drops the bits written with it, so no enable flickers on for a cycle
        next_soft_reset = 1'b1;
        next_reset_cnt = '0;
      end else begin
        // only the writable bits reach the register; the flag and bits 3 and 1 ignore writes
        next_pullup = pwdata[utci_pkg::BIT_PULLUP];
        next_resume_en = pwdata[utci_pkg::BIT_RESUME_EN];
        next_reg_en = pwdata[utci_pkg::BIT_REG_EN];
        next_bus_transceiver_en = pwdata[utci_pkg::BIT_BUS_TRANSCEIVER_EN];
      end
    end
    // resume flag: set by a k-state in suspend and stop3 while enabled
    if (lowpower_resume_enable && sleep_seen && chip_in_stop3 && k_state) begin
      next_resume_flag = 1'b1;
    end
    // clearing the enable is the only way to clear the flag
    if (!next_resume_en) begin
      next_resume_flag = 1'b0;
    end
    // module reset: hold a few cycles, drop the enables, then self-clear
    if (module_soft_reset) begin
      next_pullup = 1'b0;
      next_resume_en = 1'b0;
      next_resume_flag = 1'b0;
      next_reg_en = 1'b0;
      next_bus_transceiver_en = 1'b0;
      if (reset_cnt == 2'(utci_pkg::RESET_HOLD_CYCLES - 1)) begin
        next_soft_reset = 1'b0;
      end else begin
        next_reset_cnt = reset_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dp_pullup_select <= 1'b0;
      lowpower_resume_enable <= 1'b0;
      lowpower_resume_flag <= 1'b0;
      regulator_enable <= 1'b0;
      transceiver_enable <= 1'b0;
      module_soft_reset <= 1'b0;
      reset_cnt <= '0;
    end else begin
      dp_pullup_select <= next_pullup;
      lowpower_resume_enable <= next_resume_en;
      lowpower_resume_flag <= next_resume_flag;
      regulator_enable <= next_reg_en;
      transceiver_enable <= next_bus_transceiver_en;
      module_soft_reset <= next_soft_reset;
      reset_cnt <= next_reset_cnt;
    end
  end

  // ==========================================================
  // interrupt status and mask; a hardware set beats a software clear
  always_comb begin
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    next_sleep_seen = sleep_raw;
    if (wr_status) begin
      next_irq_status = irq_status & ~pwdata[1:0];
    end
    if (wr_mask) begin
      next_irq_mask = pwdata[1:0];
    end
    if (sleep_raw && !sleep_seen) begin
      next_irq_status[utci_pkg::IRQ_SLEEP] = 1'b1;
    end
    if (next_resume_flag && !lowpower_resume_flag) begin
      next_irq_status[utci_pkg::IRQ_RESUME] = 1'b1;
    end
    if (module_soft_reset) begin
      next_irq_status = utci_pkg::IRQ_RESET;
      // the module reset returns the mask to its reset value as well
      next_irq_mask = utci_pkg::IRQ_RESET;
      next_sleep_seen = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_status <= utci_pkg::IRQ_RESET;
      irq_mask <= utci_pkg::IRQ_RESET;
      sleep_seen <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      sleep_seen <= next_sleep_seen;
    end
  end

  // ==========================================================
  // apb answer: data captured in setup, pready in the access cycle
  always_comb begin
    next_prdata = prdata;
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !addr_ok;
    if (rd_en) begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        utci_pkg::ADDR_CTRL: next_prdata[7:0] = ctrl_view;
        utci_pkg::ADDR_ID: next_prdata[5:0] = utci_pkg::PERIPHERAL_ID;
        utci_pkg::ADDR_ID_INV: next_prdata[5:0] = ~utci_pkg::PERIPHERAL_ID;
        utci_pkg::ADDR_REV: next_prdata[7:0] = utci_pkg::CORE_REVISION;
        utci_pkg::ADDR_IRQ_STATUS: next_prdata[1:0] = irq_status;
        utci_pkg::ADDR_IRQ_MASK: next_prdata[1:0] = irq_mask;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // pin next values; the data lines float whether or not the transceiver is on,
  // since this block never transmits and the absent serial engine owns the drivers
  always_comb begin
    next_plus_oe_n = 1'b1;
    next_minus_oe_n = 1'b1;
    next_pullup_on = dp_pullup_select;
    next_regulator_on = regulator_enable;
    next_transceiver_on = transceiver_enable;
    next_module_reset = module_soft_reset;
    next_idle_sleep = sleep_seen;
    // wakeup is a level, taken straight from the flag while enabled
    next_wakeup = lowpower_resume_enable && lowpower_resume_flag;
    next_irq = |(irq_status & irq_mask);
  end

  // registered pin controls; every output leaves from a flop
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_plus_line_oe_n <= 1'b1;
      bus_minus_line_oe_n <= 1'b1;
      dp_pullup_on <= 1'b0;
      regulator_on <= 1'b0;
      transceiver_on <= 1'b0;
      module_reset <= 1'b0;
      idle_sleep_flag <= 1'b0;
      wakeup_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      bus_plus_line_oe_n <= next_plus_oe_n;
      bus_minus_line_oe_n <= next_minus_oe_n;
      dp_pullup_on <= next_pullup_on;
      regulator_on <= next_regulator_on;
      transceiver_on <= next_transceiver_on;
      module_reset <= next_module_reset;
      idle_sleep_flag <= next_idle_sleep;
      wakeup_irq <= next_wakeup;
      irq <= next_irq;
    end
  end
endmodule
`default_nettype wire

// [bench/utci_host_model.sv]
// behavioural usb host that holds the bus idle or signals resume
`default_nettype none
module utci_host_model (
  // clock
  input wire logic clk_sys,
  // request from the bench
  input wire logic send_k,
  // received line levels at the device
  output logic bus_plus_line,
  output logic bus_minus_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // line state
  // idle is j, resume signalling is k; one process drives the lines, settled at the first edge inside reset
  always @(posedge clk_sys) begin
    bus_plus_line <= ~send_k;
    bus_minus_line <= send_k;
  end
endmodule
`default_nettype wire

// [bench/utci_top_assertions.sv]
// concurrent checks on the ports of the transceiver control block
`default_nettype none
module utci_top_assertions #(
  parameter int unsigned IDLE_CYCLES = utci_pkg::IDLE_SUSPEND_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // line, power and status
  input wire logic bus_plus_line_in,
  input wire logic bus_minus_line_in,
  input wire logic chip_in_stop3,
  input wire logic bus_plus_line_oe_n,
  input wire logic bus_minus_line_oe_n,
  input wire logic dp_pullup_on,
  input wire logic regulator_on,
  input wire logic transceiver_on,
  input wire logic module_reset,
  input wire logic idle_sleep_flag,
  input wire logic wakeup_irq,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // completed transfers; soft reset writes are left out since they drop the other bits
  wire logic acc = psel && penable && pready;
  wire logic wr_ctrl = acc && pwrite && paddr == utci_pkg::ADDR_CTRL && !pwdata[7];
  wire logic rd_id = acc && !pwrite && paddr == utci_pkg::ADDR_ID;
  // ==========================================================
  // properties
  chk_lines_floated: assert property (bus_plus_line_oe_n && bus_minus_line_oe_n)
    else $error("data lines driven");
  chk_bus_transceiver_off: assert property (wr_ctrl && !pwdata[0] |-> ##[1:2] !transceiver_on)
    else $error("transceiver stays on");
  chk_pullup_on: assert property (wr_ctrl && pwdata[6] |-> ##[1:2] dp_pullup_on)
    else $error("pull-up not on");
  chk_regulator_on: assert property (wr_ctrl && pwdata[2] |-> ##[1:2] regulator_on)
    else $error("regulator not on");
  chk_soft_clears: assert property ($rose(module_reset) |-> ##[0:2] !(regulator_on || transceiver_on))
    else $error("soft reset kept enables");
  chk_reset_ends: assert property ($rose(module_reset) |-> ##[1:3] !module_reset)
    else $error("soft reset stuck");
  chk_wake_stop3: assert property ($rose(wakeup_irq) |->
    $past(chip_in_stop3) || $past(chip_in_stop3, 2) || $past(chip_in_stop3, 3))
    else $error("wakeup outside stop3");
  chk_wake_cleared: assert property (wr_ctrl && !pwdata[5] |-> ##[1:3] !wakeup_irq)
    else $error("wakeup not cleared");
  chk_id_value: assert property (rd_id |-> prdata == {26'h0, utci_pkg::PERIPHERAL_ID})
    else $error("bad identity read");
  chk_sleep_bus_transceiver: assert property ($rose(idle_sleep_flag) |-> $past(transceiver_on))
    else $error("suspend without transceiver");
endmodule
bind utci_top utci_top_assertions #(.IDLE_CYCLES(IDLE_CYCLES)) chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .bus_plus_line_in(bus_plus_line_in), .bus_minus_line_in(bus_minus_line_in),
  .chip_in_stop3(chip_in_stop3), .bus_plus_line_oe_n(bus_plus_line_oe_n), .bus_minus_line_oe_n(bus_minus_line_oe_n),
  .dp_pullup_on(dp_pullup_on), .regulator_on(regulator_on), .transceiver_on(transceiver_on),
  .module_reset(module_reset), .idle_sleep_flag(idle_sleep_flag), .wakeup_irq(wakeup_irq), .irq(irq));
`default_nettype wire

// [bench/utci_top_bench.sv]
// self-checking bench for the transceiver control block
`default_nettype none
module utci_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned IDLE = 20;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic chip_in_stop3 = 1'b0;
  logic send_k = 1'b0;
  logic seen_rst = 1'b0;
  int miscompares = 0;
  int comparisons = 0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, plus, minus, oe_p, oe_m, pull, reg_on, bus_transceiver, mrst, sleep, wake, irq;
  // ==========================================================
  // design and host
  utci_top #(.IDLE_CYCLES(IDLE)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_plus_line_in(plus), .bus_minus_line_in(minus), .chip_in_stop3(chip_in_stop3),
    .bus_plus_line_oe_n(oe_p), .bus_minus_line_oe_n(oe_m), .dp_pullup_on(pull), .regulator_on(reg_on),
    .transceiver_on(bus_transceiver), .module_reset(mrst), .idle_sleep_flag(sleep), .wakeup_irq(wake), .irq(irq));
  utci_host_model host (.clk_sys(clk_sys), .send_k(send_k), .bus_plus_line(plus), .bus_minus_line(minus));
  // ==========================================================
  // clock, soft reset monitor and watchdog
  initial forever #5 clk_sys = ~clk_sys;
  // the soft reset pulse is too short to catch after a task returns
  always @(posedge clk_sys) if (mrst === 1'b1) seen_rst <= 1'b1;
  initial begin
    #50us;
    miscompares++;
    finish_test();
  end
  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after an edge; waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_sys);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check(q, exp);
  endtask
  // registered levels: irq, wakeup, pull-up, regulator, transceiver, both line enables
  task automatic pins(input logic [6:0] exp);
    repeat (2) @(posedge clk_sys);
    check({25'h0, irq, wake, pull, reg_on, bus_transceiver, oe_p, oe_m}, {25'h0, exp});
  endtask
  task automatic finish_test();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] q;
    logic e;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd_chk(utci_pkg::ADDR_CTRL, 32'h0);
    wr(utci_pkg::ADDR_ID, 32'hffffffff);
    rd_chk(utci_pkg::ADDR_ID, {26'h0, utci_pkg::PERIPHERAL_ID});
    rd_chk(utci_pkg::ADDR_ID_INV, {26'h0, ~utci_pkg::PERIPHERAL_ID});
    rd_chk(utci_pkg::ADDR_REV, {24'h0, utci_pkg::CORE_REVISION});
    apb(1'b0, 12'h0f0, 32'h0, q, e);
    check({e, q[30:0]}, 32'h80000000);
    // control bits, then a soft reset that also drops the bits written with it
    wr(utci_pkg::ADDR_CTRL, 32'h5f);
    rd_chk(utci_pkg::ADDR_CTRL, 32'h45);
    pins(7'h1f);
    wr(utci_pkg::ADDR_CTRL, 32'h40);
    pins(7'h13);
    wr(utci_pkg::ADDR_CTRL, 32'h85);
    pins(7'h03);
    check({31'h0, seen_rst}, 32'h1);
    rd_chk(utci_pkg::ADDR_CTRL, 32'h0);
    // suspend entry after continuous idle
    wr(utci_pkg::ADDR_CTRL, 32'h01);
    repeat (IDLE / 2) @(posedge clk_sys);
    check({31'h0, sleep}, 32'h0);
    for (int i = 0; i < 4 * IDLE && sleep !== 1'b1; i++) @(posedge clk_sys);
    check({31'h0, sleep}, 32'h1);
    rd_chk(utci_pkg::ADDR_IRQ_STATUS, 32'h1);
    wr(utci_pkg::ADDR_IRQ_MASK, 32'h3);
    pins(7'h47);
    wr(utci_pkg::ADDR_IRQ_MASK, 32'h0);
    pins(7'h07);
    // resume in stop3
    wr(utci_pkg::ADDR_CTRL, 32'h21);
    chip_in_stop3 <= 1'b1;
    rd_chk(utci_pkg::ADDR_CTRL, 32'h21);
    send_k <= 1'b1;
    for (int i = 0; i < 40 && wake !== 1'b1; i++) @(posedge clk_sys);
    pins(7'h27);
    rd_chk(utci_pkg::ADDR_CTRL, 32'h31);
    rd_chk(utci_pkg::ADDR_IRQ_STATUS, 32'h3);
    chip_in_stop3 <= 1'b0;
    wr(utci_pkg::ADDR_CTRL, 32'h01);
    rd_chk(utci_pkg::ADDR_CTRL, 32'h01);
    wr(utci_pkg::ADDR_IRQ_MASK, 32'h3);
    pins(7'h47);
    wr(utci_pkg::ADDR_IRQ_STATUS, 32'h3);
    pins(7'h07);
    rd_chk(utci_pkg::ADDR_IRQ_STATUS, 32'h0);
    send_k <= 1'b0;
    finish_test();
  end
endmodule
`default_nettype wire
